// [quad_dac_serial_command_unit.sv]
// serial command decoder, register banks and readback of a quad dac
`timescale 1ns/1ps
module quad_dac_serial_command_unit (
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    input  wire logic                   clk_en,
    input  wire logic                   serial_clk,
    input  wire logic                   frame_sel_n,
    input  wire logic                   serial_in,
    input  wire logic                   load_strobe_n,
    output logic                        serial_out,
    output logic                        serial_out_oe_n,
    output logic [15:0]                 dac_a,
    output logic [15:0]                 dac_b,
    output logic [15:0]                 dac_c,
    output logic [15:0]                 dac_d,
    output logic [7:0]                  channel_power_modes,
    output logic [3:0]                  chan_powered_down,
    output logic                        chain_mode_enable
);
    localparam int FB = dac_cmd_pkg::FRAME_BITS;

    // two-flop synchronisers for the four serial link input pins
    logic [1:0] sck_s_r;                            // serial clock sync
    logic [1:0] sel_s_r;                            // frame select sync
    logic [1:0] din_s_r;                            // serial data sync
    logic [1:0] ld_s_r;                             // load strobe sync
    logic       sck_q_r;                            // previous clock
    logic       sel_q_r;                            // previous select
    logic       ld_q_r;                             // previous strobe

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            // link clock idles high: start there, so no false edge
            sck_s_r <= 2'h3;
            sel_s_r <= 2'h3;
            din_s_r <= '0;
            ld_s_r  <= 2'h3;
            sck_q_r <= 1'b1;
            sel_q_r <= 1'b1;
            ld_q_r  <= 1'b1;
        end else if (clk_en) begin
            sck_s_r <= {sck_s_r[0], serial_clk};
            sel_s_r <= {sel_s_r[0], frame_sel_n};
            din_s_r <= {din_s_r[0], serial_in};
            ld_s_r  <= {ld_s_r[0], load_strobe_n};
            sck_q_r <= sck_s_r[1];
            sel_q_r <= sel_s_r[1];
            ld_q_r  <= ld_s_r[1];
        end
    end

    logic sck_rise, sck_fall, sel_fall, sel_rise, ld_fall, in_frame;
    assign sck_rise = sck_s_r[1] && !sck_q_r;
    assign sck_fall = !sck_s_r[1] && sck_q_r;
    assign sel_fall = !sel_s_r[1] && sel_q_r;
    assign sel_rise = sel_s_r[1] && !sel_q_r;
    assign ld_fall  = !ld_s_r[1] && ld_q_r;
    assign in_frame = !sel_s_r[1];

    // input shift register; its top bit feeds serial_out outside readback
    logic [FB-1:0] shift_r;                         // input shift register
    logic [5:0]    bit_cnt_r;                       // bits this frame
    logic          frame_live_r;                    // frame accepting bits

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            shift_r      <= '0;
            bit_cnt_r    <= '0;
            frame_live_r <= 1'b0;
        end else if (clk_en) begin
            if (sel_fall) begin
                bit_cnt_r    <= '0;
                frame_live_r <= 1'b1;
            end else if (sel_rise) begin
                frame_live_r <= 1'b0;
            end else if (frame_live_r && in_frame && sck_fall) begin
                // sample on falling edge, msb first
                shift_r    <= {shift_r[FB-2:0], din_s_r[1]};
                if (bit_cnt_r != 6'h3F) begin
                    bit_cnt_r <= bit_cnt_r + 6'h01;
                end
            end
        end
    end

    // frames queued towards the executor
    dac_cmd_pkg::frame_t fifo_out;                  // frame at fifo head
    logic [FB-1:0]       fifo_raw;                  // raw head bits
    logic                fifo_valid;                // head present
    logic                fifo_in_ready;             // space for a frame
    logic                exec_ready;                // executor takes head
    logic                lost_frame_r;              // frame dropped, full

    frame_fifo #(
        .WIDTH (FB),
        .DEPTH (dac_cmd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .clk_en    (clk_en),
        .in_data   (shift_r),
        .in_valid  (sel_rise && frame_live_r),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_raw),
        .out_valid (fifo_valid),
        .out_ready (exec_ready)
    );
    assign fifo_out = dac_cmd_pkg::frame_t'(fifo_raw);

    // the executor takes one frame per cycle, so the head never waits
    assign exec_ready = 1'b1;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lost_frame_r <= 1'b0;
        end else if (clk_en && sel_rise && frame_live_r && !fifo_in_ready) begin
            lost_frame_r <= 1'b1;
        end
    end

    // register banks
    logic [15:0] input_reg_r [dac_cmd_pkg::NUM_CHAN]; // input bank
    logic [15:0] dac_reg_r   [dac_cmd_pkg::NUM_CHAN]; // dac bank
    logic [1:0]  rb_sel_r;                          // readback channel
    logic        rb_armed_r;                        // load word next frame
    logic        rb_active_r;                       // readback frame running
    logic        do_cmd;                            // execute head frame

    assign do_cmd = clk_en && fifo_valid;

    // picks the single selected channel, else channel a
    function automatic logic [1:0] rb_chan(input logic [3:0] sel);
        unique case (sel)
            4'h2:    rb_chan = 2'h1;
            4'h4:    rb_chan = 2'h2;
            4'h8:    rb_chan = 2'h3;
            default: rb_chan = 2'h0;
        endcase
    endfunction

    // input and dac register updates
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int i = 0; i < dac_cmd_pkg::NUM_CHAN; i++) begin
                input_reg_r[i] <= '0;
                dac_reg_r[i]   <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < dac_cmd_pkg::NUM_CHAN; i++) begin
                // strobe fall with no frame open moves input to dac
                if (ld_fall && sel_s_r[1]) begin
                    dac_reg_r[i] <= input_reg_r[i];
                end
                if (do_cmd && fifo_out.chan_sel[i]) begin
                    unique case (fifo_out.command_code)
                        dac_cmd_pkg::CMD_WR_INPUT: begin
                            input_reg_r[i] <= fifo_out.data;
                            if (!ld_s_r[1]) begin
                                dac_reg_r[i] <= fifo_out.data;
                            end
                        end
                        dac_cmd_pkg::CMD_UPD_DAC: begin
                            dac_reg_r[i] <= input_reg_r[i];
                        end
                        dac_cmd_pkg::CMD_WR_UPDATE: begin
                            // written even when powered down
                            input_reg_r[i] <= fifo_out.data;
                            dac_reg_r[i]   <= fifo_out.data;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    // mode registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            chain_mode_enable   <= dac_cmd_pkg::CHAIN_RESET;
            channel_power_modes <= dac_cmd_pkg::POWER_RESET;
            rb_sel_r            <= '0;
            rb_armed_r          <= 1'b0;
        end else if (do_cmd) begin
            if (fifo_out.command_code == dac_cmd_pkg::CMD_CHAIN) begin
                chain_mode_enable <= fifo_out.data[0];
            end
            if (fifo_out.command_code == dac_cmd_pkg::CMD_POWER) begin
                channel_power_modes <= fifo_out.data[7:0];
            end
            // any frame ends an armed readback, 1001 re-arms it
            rb_armed_r <= fifo_out.command_code == dac_cmd_pkg::CMD_READBACK;
            if (fifo_out.command_code == dac_cmd_pkg::CMD_READBACK) begin
                rb_sel_r <= rb_chan(fifo_out.chan_sel);
            end
        end
    end

    // per channel power-down flags; codes 1,2,3 are 1k, 100k, open
    always_comb begin
        for (int i = 0; i < dac_cmd_pkg::NUM_CHAN; i++) begin
            chan_powered_down[i] = channel_power_modes[2*i +: 2]
                                   != dac_cmd_pkg::PM_NORMAL;
        end
    end

    assign dac_a = dac_reg_r[0];
    assign dac_b = dac_reg_r[1];
    assign dac_c = dac_reg_r[2];
    assign dac_d = dac_reg_r[3];

    // output shifter: readback word or chain pass-through
    logic [FB-1:0] rb_word_r;                       // word being read back
    logic          sout_r;                          // serial_out flop

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rb_word_r   <= '0;
            rb_active_r <= 1'b0;
            sout_r      <= 1'b0;
        end else if (clk_en) begin
            if (sel_fall) begin
                rb_active_r <= rb_armed_r;
                // value in 19..4; low bits zero, the undefined ones
                rb_word_r   <= FB'(dac_reg_r[rb_sel_r])
                               << dac_cmd_pkg::RB_SHIFT;
                // the host samples before the first rise: present the
                // top bit of the word at once
                if (rb_armed_r) begin
                    sout_r <= 1'b0;
                end
            end else if (sel_rise) begin
                rb_active_r <= 1'b0;
            end else if (in_frame && sck_rise) begin
                // change on rising clock edge
                if (rb_active_r) begin
                    sout_r    <= rb_word_r[FB-2];
                    rb_word_r <= {rb_word_r[FB-2:0], 1'b0};
                end else begin
                    sout_r <= shift_r[FB-1];
                end
            end
        end
    end

    assign serial_out      = sout_r;
    // driven only in chain mode or during a readback frame
    assign serial_out_oe_n = !(chain_mode_enable || rb_active_r);

    // assertions
    a_chain_write: assert property (
        @(posedge sys_clk) disable iff (srst)
        do_cmd && fifo_out.command_code == dac_cmd_pkg::CMD_CHAIN
        |=> chain_mode_enable == $past(fifo_raw[0]))
        else $error("chain enable not loaded");
    a_wr_update: assert property (
        @(posedge sys_clk) disable iff (srst)
        do_cmd && fifo_out.command_code == dac_cmd_pkg::CMD_WR_UPDATE
        && fifo_out.chan_sel[0] |=> dac_a == $past(fifo_out.data))
        else $error("write and update missed channel a");
    a_power_load: assert property (
        @(posedge sys_clk) disable iff (srst)
        do_cmd && fifo_out.command_code == dac_cmd_pkg::CMD_POWER
        |=> channel_power_modes == $past(fifo_raw[7:0]))
        else $error("power modes not loaded");
    a_power_flag: assert property (
        @(posedge sys_clk) disable iff (srst)
        chan_powered_down[3] == (channel_power_modes[7:6] != 2'h0))
        else $error("power flag wrong for channel d");
    a_count_clear: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && sel_fall |=> bit_cnt_r == 6'h00)
        else $error("bit count not cleared");
    a_frame_push: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && sel_rise && frame_live_r && fifo_in_ready
        |=> fifo_valid)
        else $error("frame not queued on select rise");
    a_strobe_hold: assert property (
        @(posedge sys_clk) disable iff (srst)
        do_cmd && fifo_out.command_code == dac_cmd_pkg::CMD_WR_INPUT
        && fifo_out.chan_sel[1] && ld_s_r[1] && !ld_fall
        |=> $stable(dac_b))
        else $error("dac changed with strobe high");
    a_strobe_low: assert property (
        @(posedge sys_clk) disable iff (srst)
        do_cmd && fifo_out.command_code == dac_cmd_pkg::CMD_WR_INPUT
        && fifo_out.chan_sel[2] && !ld_s_r[1]
        |=> dac_c == $past(fifo_out.data))
        else $error("dac not updated with strobe low");
    a_sdo_enable: assert property (
        @(posedge sys_clk) disable iff (srst)
        rb_active_r |-> !serial_out_oe_n)
        else $error("serial out off during readback");
    // the queue never fills at legal frame spacing
    a_no_lost_frame: assert property (
        @(posedge sys_clk) disable iff (srst)
        !lost_frame_r)
        else $error("frame lost with queue full");
    // no bit enters once the frame has closed
    a_shift_stop: assert property (
        @(posedge sys_clk) disable iff (srst)
        !frame_live_r |=> $stable(shift_r))
        else $error("shift register moved outside frame");
    // 0001 always lands in the input bank
    a_input_write: assert property (
        @(posedge sys_clk) disable iff (srst)
        do_cmd && fifo_out.command_code == dac_cmd_pkg::CMD_WR_INPUT
        && fifo_out.chan_sel[0] |=> input_reg_r[0] == $past(fifo_out.data))
        else $error("input register not written");
    // 0010 copies the input register to the dac register
    a_dac_from_input: assert property (
        @(posedge sys_clk) disable iff (srst)
        do_cmd && fifo_out.command_code == dac_cmd_pkg::CMD_UPD_DAC
        && fifo_out.chan_sel[1] |=> dac_b == $past(input_reg_r[1]))
        else $error("dac not loaded from input register");
    // strobe fall with select high copies the bank
    a_deferred_copy: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && ld_fall && sel_s_r[1] && !do_cmd
        |=> dac_a == $past(input_reg_r[0]))
        else $error("strobe fall did not update dac a");
    // power commands leave the dac bank alone
    a_power_keeps_dac: assert property (
        @(posedge sys_clk) disable iff (srst)
        do_cmd && fifo_out.command_code == dac_cmd_pkg::CMD_POWER
        && !ld_fall |=> $stable(dac_a))
        else $error("power command changed dac a");
    // several selects arm channel a
    a_readback_arm: assert property (
        @(posedge sys_clk) disable iff (srst)
        do_cmd && fifo_out.command_code == dac_cmd_pkg::CMD_READBACK
        && fifo_out.chan_sel == 4'hC |=> rb_armed_r && rb_sel_r == 2'h0)
        else $error("readback not armed on channel a");
    // first readback bit stands before the first rise
    a_rb_first_bit: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && sel_fall && rb_armed_r |=> !serial_out)
        else $error("readback word not presented at frame start");
    // outside readback, serial_out follows the top shift bit
    a_chain_pass: assert property (
        @(posedge sys_clk) disable iff (srst)
        clk_en && in_frame && sck_rise && !sel_fall && !rb_active_r
        |=> serial_out == $past(shift_r[FB-1]))
        else $error("pass-through bit wrong");
    c_readback: cover property (@(posedge sys_clk) rb_active_r && sck_rise);
    c_chain: cover property (@(posedge sys_clk) chain_mode_enable && sck_rise);
    c_deferred: cover property (@(posedge sys_clk) ld_fall && sel_s_r[1]);
    c_odd_frame: cover property (@(posedge sys_clk)
        sel_rise && frame_live_r && bit_cnt_r != 6'(FB));
    c_strobe_low: cover property (@(posedge sys_clk)
        do_cmd && !ld_s_r[1]);
endmodule

// [dac_cmd_pkg.sv]
// shared constants and carrier types for the serial dac command unit
package dac_cmd_pkg;
    localparam int FRAME_BITS = 24;                 // bits per frame
    localparam int CMD_HI     = 23;                 // command field msb
    localparam int CMD_LO     = 20;                 // command field lsb
    localparam int ADDR_HI    = 19;                 // channel select msb
    localparam int ADDR_LO    = 16;                 // channel select lsb
    localparam int DATA_HI    = 15;                 // data word msb
    localparam int RES_BITS   = 16;                 // dac register width
    localparam int NUM_CHAN   = 4;                  // channels a..d
    localparam int PM_BITS    = 8;                  // power mode field
    localparam int RB_SHIFT   = 4;                  // readback value lsb
    localparam int FIFO_DEPTH = 16;                 // frame fifo depth
    localparam logic [3:0] CMD_NOP        = 4'h0;   // no_operation
    localparam logic [3:0] CMD_WR_INPUT   = 4'h1;   // write input reg
    localparam logic [3:0] CMD_UPD_DAC    = 4'h2;   // input to dac
    localparam logic [3:0] CMD_WR_UPDATE  = 4'h3;   // write and update
    localparam logic [3:0] CMD_POWER      = 4'h4;   // power modes
    localparam logic [3:0] CMD_CHAIN      = 4'h8;   // chain enable
    localparam logic [3:0] CMD_READBACK   = 4'h9;   // arm readback
    localparam logic [3:0] CMD_NOP_CHAIN  = 4'hF;   // chain no_operation
    localparam logic       CHAIN_RESET    = 1'b0;   // standalone default
    localparam logic [7:0] POWER_RESET    = 8'h00;  // all channels normal
    localparam logic [1:0] PM_NORMAL      = 2'h0;   // normal operation
    localparam logic [1:0] PM_1K          = 2'h1;   // 1k to ground
    localparam logic [1:0] PM_100K        = 2'h2;   // 100k to ground
    localparam logic [1:0] PM_OPEN        = 2'h3;   // high impedance

    // one received frame as it leaves the shift register
    typedef struct packed {
        logic [3:0]  command_code;                  // command field
        logic [3:0]  chan_sel;                      // channel select
        logic [15:0] data;                          // data word
    } frame_t;
endpackage

// [frame_fifo.sv]
// parameterised valid/ready fifo for received frames
`timescale 1ns/1ps
module frame_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];                  // storage
    logic [AW-1:0]    wr_ptr_r;                     // write pointer
    logic [AW-1:0]    rd_ptr_r;                     // read pointer
    logic [AW:0]      count_r;                      // fill level
    logic             push;                         // write this cycle
    logic             pop;                          // read this cycle

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready && clk_en;
    assign pop       = out_valid && out_ready && clk_en;
    assign out_data  = mem[rd_ptr_r];

    // storage write
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [host_link_model.sv]
// host side of the serial link: frames, clocks and samples serial_out
`timescale 1ns/1ps
module host_link_model #(
    parameter int HALF_NS = 80                  // half link clock period
) (
    output logic      serial_clk,
    output logic      frame_sel_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe_n
);
    logic [47:0] rx_r;                          // bits sampled from serial_out
    logic        oe_low_r;                      // output enabled at every bit
    logic        sdo_seen;                      // line, pulled high when off

    // a released serial_out floats to its pull-up level
    assign sdo_seen = serial_out_oe_n ? 1'b1 : serial_out;

    // idle state: clock stands high, select released
    initial begin
        serial_clk  = 1'b1;
        frame_sel_n = 1'b1;
        serial_in   = 1'b0;
        rx_r        = 48'h0;
        oe_low_r    = 1'b0;
    end

    // gated burst of n bits, msb first, then select rises
    task automatic send(input logic [47:0] word, input int n);
        int i;
        rx_r     = 48'h0;
        oe_low_r = 1'b1;
        #3 frame_sel_n = 1'b0;
        for (i = n - 1; i >= 0; i--) begin
            serial_in = word[i];
            #HALF_NS;
            // sample downstream data on the falling edge
            rx_r     = {rx_r[46:0], sdo_seen};
            oe_low_r = oe_low_r & ~serial_out_oe_n;
            serial_clk = 1'b0;
            #HALF_NS;
            serial_clk = 1'b1;
        end
        #HALF_NS;
        frame_sel_n = 1'b1;
        // released data line must not look like held data
        serial_in = ~serial_in;
        // select stays high long enough for the frame to execute
        #(4 * HALF_NS);
    endtask
endmodule

// [tb_quad_dac_serial_command_unit.sv]
// self-checking bench for the serial dac command unit and frame fifo
`timescale 1ns/1ps
module tb_quad_dac_serial_command_unit;
    logic        sys_clk = 1'b0;                // 100 MHz clock
    logic        srst = 1'b1;                   // sync reset
    logic        clk_en = 1'b1;                 // run enable
    logic        load_strobe_n = 1'b1;          // load strobe, idle high
    wire         serial_clk;                    // link clock from host
    wire         frame_sel_n;                   // frame select from host
    wire         serial_in;                     // data from host
    logic        serial_out;                    // data to host
    logic        serial_out_oe_n;               // serial_out enable
    logic [15:0] dac_a, dac_b, dac_c, dac_d;    // dac registers
    logic [7:0]  channel_power_modes;           // power mode field
    logic [3:0]  chan_powered_down;             // per channel power-down
    logic        chain_mode_enable;             // chain mode flag
    int          mismatches = 0;
    int          total_checks = 0;

    // clock
    always #5 sys_clk = ~sys_clk;

    quad_dac_serial_command_unit u_dut (
        .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en),
        .serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
        .serial_in(serial_in), .load_strobe_n(load_strobe_n),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .dac_a(dac_a), .dac_b(dac_b), .dac_c(dac_c), .dac_d(dac_d),
        .channel_power_modes(channel_power_modes),
        .chan_powered_down(chan_powered_down),
        .chain_mode_enable(chain_mode_enable)
    );

    host_link_model u_host (
        .serial_clk(serial_clk), .frame_sel_n(frame_sel_n),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n)
    );

    // prints the counts and the verdict, then ends the run
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // compares one value
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // compares all four dac registers
    task automatic chk_dacs(input logic [15:0] a, b, c, d);
        chk({8'h00, dac_a}, {8'h00, a});
        chk({8'h00, dac_b}, {8'h00, b});
        chk({8'h00, dac_c}, {8'h00, c});
        chk({8'h00, dac_d}, {8'h00, d});
    endtask

    // one standard 24-bit frame
    task automatic frame(input logic [23:0] w);
        u_host.send({24'h000000, w}, 24);
    endtask

    // reset state of registers and serial_out enable
    task automatic sc_reset();
        chk_dacs(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        chk({23'h0, chain_mode_enable}, 24'h000000);
        chk({16'h0, channel_power_modes}, 24'h000000);
        chk({23'h0, serial_out_oe_n}, 24'h000001);
    endtask

    // write-and-update to b and d, strobe high
    task automatic sc_write_update();
        frame(24'h3A1234);
        chk_dacs(16'h0000, 16'h1234, 16'h0000, 16'h1234);
    endtask

    // deferred then immediate update through the load strobe
    task automatic sc_strobe();
        frame(24'h11ABCD);
        chk_dacs(16'h0000, 16'h1234, 16'h0000, 16'h1234);
        @(posedge sys_clk);
        load_strobe_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk_dacs(16'hABCD, 16'h1234, 16'h0000, 16'h1234);
        frame(24'h145678);
        chk({8'h00, dac_c}, 24'h005678);
        @(posedge sys_clk);
        load_strobe_n <= 1'b1;
    endtask

    // power modes with ignored fields, writes while powered down
    task automatic sc_power();
        frame(24'h4FA5E4);
        chk({16'h0, channel_power_modes}, 24'h0000E4);
        chk({20'h0, chan_powered_down}, 24'h00000E);
        frame(24'h320F0F);
        chk({8'h00, dac_b}, 24'h000F0F);
        chk({16'h0, channel_power_modes}, 24'h0000E4);
        frame(24'h400000);
        chk({20'h0, chan_powered_down}, 24'h000000);
    endtask

    // arms readback with cmd, then reads it in a no_operation frame
    task automatic readback(input logic [23:0] cmd, no_operation, input logic [15:0] e);
        frame(cmd);
        frame(no_operation);
        chk({8'h00, u_host.rx_r[19:4]}, {8'h00, e});
        chk({23'h0, u_host.oe_low_r}, 24'h000001);
    endtask

    // readback of one channel, of several and of none
    task automatic sc_readback();
        readback(24'h920000, 24'h000000, 16'h0F0F);
        chk({23'h0, serial_out_oe_n}, 24'h000001);
        readback(24'h9C0000, 24'h000000, 16'hABCD);
        readback(24'h900000, 24'h000000, 16'hABCD);
    endtask

    // odd clock count still executes the last 24 bits
    task automatic sc_odd_frame();
        u_host.send({23'h0, 1'b1, 24'h315555}, 25);
        chk({8'h00, dac_a}, 24'h005555);
    endtask

    // daisy chain pass-through and chain readback
    task automatic sc_chain();
        frame(24'h800001);
        chk({23'h0, chain_mode_enable}, 24'h000001);
        chk({23'h0, serial_out_oe_n}, 24'h000000);
        u_host.send({24'h332222, 24'h384444}, 48);
        chk(u_host.rx_r[23:0], 24'h332222);
        chk_dacs(16'h5555, 16'h0F0F, 16'h5678, 16'h4444);
        readback(24'h980000, 24'hF00000, 16'h4444);
        frame(24'h800000);
        chk({23'h0, chain_mode_enable}, 24'h000000);
    endtask

    // frames through the frame queue in order, 0010, a reserved
    // command, then a bounded wait on a strobe update
    task automatic sc_fifo();
        int k;
        frame(24'h3F1111);
        frame(24'h312222);
        chk_dacs(16'h2222, 16'h1111, 16'h1111, 16'h1111);
        frame(24'h12BEEF);
        frame(24'h220000);
        chk({8'h00, dac_b}, 24'h00BEEF);
        frame(24'h5F0000);
        chk_dacs(16'h2222, 16'hBEEF, 16'h1111, 16'h1111);
        frame(24'h14CAFE);
        @(posedge sys_clk);
        load_strobe_n <= 1'b0;
        k = 0;
        while (k < 16 && dac_c !== 16'hCAFE) begin
            @(posedge sys_clk);
            k++;
        end
        load_strobe_n <= 1'b1;
        // an update that never comes counts and goes to the report
        if (k == 16) begin
            mismatches++;
            return;
        end
        chk_dacs(16'h2222, 16'hBEEF, 16'hCAFE, 16'h1111);
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        sc_reset();
        sc_write_update();
        sc_strobe();
        sc_power();
        sc_readback();
        sc_odd_frame();
        sc_chain();
        sc_fifo();
        conclude();
    end
endmodule
